// ---- core/tap_consts.svh ----
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// Instruction register geometry
`define TAP_IR_W 3
// Fixed pattern loaded when an instruction scan starts
`define TAP_IR_CAPTURE 3'h4
// Instruction codes
`define TAP_OP_EXTEST 3'h0
`define TAP_OP_IDCODE 3'h1
`define TAP_OP_SAMPLE 3'h6
`define TAP_OP_HIGHZ 3'h2
`define TAP_OP_CLAMP 3'h3
`define TAP_OP_FACTORY 3'h5
`define TAP_OP_BYPASS 3'h7

// Data register lengths
`define TAP_BSR_W 78
`define TAP_ID_W 32
// Identification register fields
`define TAP_ID_MFR_W 11
`define TAP_ID_PART_W 16
`define TAP_ID_VER_W 4
`define TAP_ID_FIXED 1'h1

// Reset values and bypass capture value
`define TAP_IR_RST `TAP_OP_IDCODE
`define TAP_BSR_RST 78'h0
`define TAP_BYP_CAPTURE 1'h0

// Consecutive high TMS samples that force the reset state
`define TAP_TMS_RESET_EDGES 5

`endif

// ---- core/tap_pkg.sv ----
package tap_pkg;

    // Controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR   = 16'h0001,
        ST_IDLE  = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PSDR  = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDDR = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PSIR  = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPDIR = 16'h8000
    } tap_state_t;

    // Which data register sits between the serial pins
    typedef enum logic [2:0] {
        SEL_BYP = 3'h1,
        SEL_ID  = 3'h2,
        SEL_BSR = 3'h4
    } dr_sel_t;

endpackage

// ---- core/tap_sync.sv ----
`timescale 1ns/100ps

// Two-stage level synchroniser, W independent bits
module tap_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // Both stages held in one record
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    // First stage feeds only the second
    always_comb begin
        s_next.meta = d;
        s_next.q = s_reg.meta;
    end

    // Synchronous clear to zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.q;

endmodule

// ---- core/tap_update_reg.sv ----
`timescale 1ns/100ps

// Falling-edge parallel latch with load enable
module tap_update_reg #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic tck,
    input wire logic rst_b,
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // Held value
    typedef struct packed {
        logic [W-1:0] val;
    } upd_t;

    upd_t u_reg;
    upd_t u_next;

    // Load only while enabled
    always_comb begin
        u_next = u_reg;
        if (en) begin
            u_next.val = d;
        end
    end

    // Updates land on the falling edge
    always_ff @(negedge tck) begin
        if (!rst_b) begin
            u_reg.val <= RST;
        end else begin
            u_reg <= u_next;
        end
    end

    assign q = u_reg.val;

endmodule

// ---- core/tap_controller.sv ----
`timescale 1ns/100ps
`include "tap_consts.svh"

// Summary of operation
// RL1: Sixteen states, TMS sampled each TCK rise
// RL2: Reset state disables test, loads IDCODE
// RL3: Five high TMS edges force reset
// RL4: Idle holds on low TMS, else Select-DR
// RL5: Select-DR: low captures, high Select-IR
// RL6: Capture-DR samples pins for EXTEST/SAMPLE
// RL7: Capture-DR: high Exit1-DR, low Shift-DR
// RL8: Shift-DR shifts toward TDO, high exits
// RL9: Exit1-DR: high Update-DR, low Pause-DR
// RL10: Pause-DR holds data, high goes Exit2-DR
// RL11: Exit2-DR: high Update-DR, low Shift-DR
// RL12: Boundary outputs latch only in Update-DR
// RL13: Select-IR: low captures, high to reset
// RL14: Capture-IR loads fixed pattern 100
// RL15: Capture-IR: high Exit1-IR, low Shift-IR
// RL16: Shift-IR shifts toward TDO, high exits
// RL17: Exit1-IR: high Update-IR, low Pause-IR
// RL18: Instruction changes only in Update-IR or the reset state
// RL19: Pause-IR holds, high goes Exit2-IR
// RL20: Exit2-IR: high Update-IR, low Shift-IR
// RL21: Update-IR latches instruction on falling edge
// RL22: Update states: high Select-DR, low Idle
// RL23: Reset state with low TMS goes Idle
module tap_controller
    import tap_pkg::*;
#(
    // Identification fields, values arbitrary
    parameter logic [`TAP_ID_VER_W-1:0] ID_VERSION = 4'h1,
    parameter logic [`TAP_ID_PART_W-1:0] ID_PART = 16'h1234,
    parameter logic [`TAP_ID_MFR_W-1:0] ID_MFR = 11'h055
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`TAP_BSR_W-1:0] bsr_pins_in,
    output logic [`TAP_BSR_W-1:0] bsr_pins_out,
    output logic bsr_drive,
    output logic test_drive,
    output logic test_highz,
    output logic test_reset
);

    // Link-domain state record
    typedef struct packed {
        tap_state_t state;
        logic [`TAP_IR_W-1:0] ir_sh;
        logic [`TAP_BSR_W-1:0] bsr_sh;
        logic [`TAP_ID_W-1:0] id_sh;
        logic byp_sh;
        logic drive;
        logic highz;
        logic in_reset;
    } tap_t;

    tap_t t_reg;
    tap_t t_next;

    logic tck_rst_b; // Reset carried into the link domain
    logic [`TAP_BSR_W-1:0] pins_sync; // Pin levels after two stages
    logic [`TAP_IR_W-1:0] ir_cur; // Current instruction
    logic [`TAP_BSR_W-1:0] bsr_par; // Latched boundary outputs
    dr_sel_t dr_sel; // Selected data register
    logic ir_load; // Instruction latch enable
    logic [`TAP_IR_W-1:0] ir_load_val; // Value for the latch
    logic bsr_load; // Boundary latch enable
    logic serial_out; // Bit presented toward TDO
    logic in_shift; // Either shift state
    logic [2:0] sys_levels; // Levels seen on mclk
    logic [1:0] tdo_pair; // Registered enable and data

    // System reset brought onto TCK
    tap_sync #(.W(1)) u_rst_sync (
        .clk(tck),
        .rst_b(1'b1),
        .d(rst_b),
        .q(tck_rst_b)
    );

    // Pin values settled before capture
    tap_sync #(.W(`TAP_BSR_W)) u_pin_sync (
        .clk(tck),
        .rst_b(tck_rst_b),
        .d(bsr_pins_in),
        .q(pins_sync)
    );

    // Register selection from the current instruction
    always_comb begin
        unique case (ir_cur)
            `TAP_OP_IDCODE: dr_sel = SEL_ID;
            `TAP_OP_EXTEST, `TAP_OP_SAMPLE: dr_sel = SEL_BSR;
            default: dr_sel = SEL_BYP;
        endcase
    end

    // Controller and shift paths
    always_comb begin
        t_next = t_reg;
        // RL1: next state per TMS
        unique case (t_reg.state)
            // RL23: leave reset on low
            ST_TLR: t_next.state = tms ? ST_TLR : ST_IDLE;
            // RL4: idle hold
            ST_IDLE: t_next.state = tms ? ST_SELDR : ST_IDLE;
            // RL5: choose branch
            ST_SELDR: t_next.state = tms ? ST_SELIR : ST_CAPDR;
            // RL7: leave capture
            ST_CAPDR: t_next.state = tms ? ST_EX1DR : ST_SHDR;
            // RL8: stay or exit
            ST_SHDR: t_next.state = tms ? ST_EX1DR : ST_SHDR;
            // RL9: update or pause
            ST_EX1DR: t_next.state = tms ? ST_UPDDR : ST_PSDR;
            // RL10: pause until high
            ST_PSDR: t_next.state = tms ? ST_EX2DR : ST_PSDR;
            // RL11: update or resume
            ST_EX2DR: t_next.state = tms ? ST_UPDDR : ST_SHDR;
            // RL22: after data update
            ST_UPDDR: t_next.state = tms ? ST_SELDR : ST_IDLE;
            // RL13: capture or reset
            ST_SELIR: t_next.state = tms ? ST_TLR : ST_CAPIR;
            // RL15: leave capture
            ST_CAPIR: t_next.state = tms ? ST_EX1IR : ST_SHIR;
            // RL16: stay or exit
            ST_SHIR: t_next.state = tms ? ST_EX1IR : ST_SHIR;
            // RL17: update or pause
            ST_EX1IR: t_next.state = tms ? ST_UPDIR : ST_PSIR;
            // RL19: pause until high
            ST_PSIR: t_next.state = tms ? ST_EX2IR : ST_PSIR;
            // RL20: update or resume
            ST_EX2IR: t_next.state = tms ? ST_UPDIR : ST_SHIR;
            // RL22: after instruction update
            ST_UPDIR: t_next.state = tms ? ST_SELDR : ST_IDLE;
            // Illegal code falls back to reset
            default: t_next.state = ST_TLR;
        endcase

        // Data register capture and shift
        if (t_reg.state == ST_CAPDR) begin
            // RL6: pins only for boundary instructions
            if (dr_sel == SEL_BSR) begin
                t_next.bsr_sh = pins_sync;
            end
            if (dr_sel == SEL_ID) begin
                t_next.id_sh = {ID_VERSION, ID_PART, ID_MFR, `TAP_ID_FIXED};
            end
            if (dr_sel == SEL_BYP) begin
                t_next.byp_sh = `TAP_BYP_CAPTURE;
            end
        end else if (t_reg.state == ST_SHDR) begin
            // RL8: one stage toward TDO
            unique case (dr_sel)
                SEL_BSR: t_next.bsr_sh = {tdi, t_reg.bsr_sh[`TAP_BSR_W-1:1]};
                SEL_ID: t_next.id_sh = {tdi, t_reg.id_sh[`TAP_ID_W-1:1]};
                SEL_BYP: t_next.byp_sh = tdi;
                default: t_next.byp_sh = tdi;
            endcase
        end

        // Instruction shift path
        if (t_reg.state == ST_CAPIR) begin
            // RL14: fixed capture pattern
            t_next.ir_sh = `TAP_IR_CAPTURE;
        end else if (t_reg.state == ST_SHIR) begin
            // RL16: one stage toward TDO
            t_next.ir_sh = {tdi, t_reg.ir_sh[`TAP_IR_W-1:1]};
        end

        // RL2: test logic off in reset state
        t_next.in_reset = (t_reg.state == ST_TLR);
        t_next.drive = !t_next.in_reset &&
            (ir_cur == `TAP_OP_EXTEST || ir_cur == `TAP_OP_CLAMP);
        t_next.highz = !t_next.in_reset && (ir_cur == `TAP_OP_HIGHZ);
    end

    // Rising-edge register of the link logic
    always_ff @(posedge tck) begin
        if (!tck_rst_b) begin
            t_reg.state <= ST_TLR;
            t_reg.ir_sh <= `TAP_IR_RST;
            t_reg.bsr_sh <= `TAP_BSR_RST;
            t_reg.id_sh <= '0;
            t_reg.byp_sh <= 1'b0;
            t_reg.drive <= 1'b0;
            t_reg.highz <= 1'b0;
            t_reg.in_reset <= 1'b1;
        end else begin
            t_reg <= t_next;
        end
    end

    // RL21: instruction latch, also set in reset state
    assign ir_load = (t_reg.state == ST_UPDIR) || (t_reg.state == ST_TLR);
    assign ir_load_val = (t_reg.state == ST_TLR) ? `TAP_IR_RST : t_reg.ir_sh;

    // RL18: only the update state or reset loads it
    tap_update_reg #(.W(`TAP_IR_W), .RST(`TAP_IR_RST)) u_ir_upd (
        .tck(tck),
        .rst_b(tck_rst_b),
        .en(ir_load),
        .d(ir_load_val),
        .q(ir_cur)
    );

    // RL12: boundary latch only in Update-DR
    assign bsr_load = (t_reg.state == ST_UPDDR) && (dr_sel == SEL_BSR);

    tap_update_reg #(.W(`TAP_BSR_W), .RST(`TAP_BSR_RST)) u_bsr_upd (
        .tck(tck),
        .rst_b(tck_rst_b),
        .en(bsr_load),
        .d(t_reg.bsr_sh),
        .q(bsr_par)
    );

    // Serial output mux
    assign in_shift = (t_reg.state == ST_SHDR) || (t_reg.state == ST_SHIR);

    always_comb begin
        serial_out = 1'b0;
        if (t_reg.state == ST_SHIR) begin
            serial_out = t_reg.ir_sh[0];
        end else if (t_reg.state == ST_SHDR) begin
            unique case (dr_sel)
                SEL_BSR: serial_out = t_reg.bsr_sh[0];
                SEL_ID: serial_out = t_reg.id_sh[0];
                default: serial_out = t_reg.byp_sh;
            endcase
        end
    end

    // TDO changes on the falling edge
    tap_update_reg #(.W(2), .RST(2'h0)) u_tdo (
        .tck(tck),
        .rst_b(tck_rst_b),
        .en(1'b1),
        .d({in_shift, serial_out}),
        .q(tdo_pair)
    );

    assign tdo_oe = tdo_pair[1];
    assign tdo = tdo_pair[0];
    assign bsr_pins_out = bsr_par;
    assign bsr_drive = t_reg.drive;

    // Test levels toward the system clock
    tap_sync #(.W(3)) u_sys_sync (
        .clk(mclk),
        .rst_b(rst_b),
        .d({t_reg.in_reset, t_reg.highz, t_reg.drive}),
        .q(sys_levels)
    );

    assign test_drive = sys_levels[0];
    assign test_highz = sys_levels[1];
    assign test_reset = sys_levels[2];

    // RL3: forced reset by high TMS
    a_tms_five_reset: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL3
        tms [*5] |=> (t_reg.state == ST_TLR))
        else $error("five high TMS did not reach reset");

    // RL4: idle holds with stable instruction
    a_idle_hold: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL4
        (t_reg.state == ST_IDLE) && !tms |=> (t_reg.state == ST_IDLE) ##0 $stable(ir_cur))
        else $error("idle not held");

    // RL5: branch from Select-DR
    a_sel_dr_branch: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL5
        (t_reg.state == ST_SELDR) |=>
            (t_reg.state == ($past(tms) ? ST_SELIR : ST_CAPDR)))
        else $error("wrong branch from Select-DR");

    // RL14: capture pattern present after Capture-IR
    a_capir_pattern: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL14
        (t_reg.state == ST_CAPIR) |=> (t_reg.ir_sh == `TAP_IR_CAPTURE))
        else $error("capture pattern missing");

    // RL12: boundary outputs move only in Update-DR
    a_bsr_par_stable: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL12
        // State sampled at this rise is the one seen by the preceding fall
        !$stable(bsr_par) |-> (t_reg.state == ST_UPDDR))
        else $error("boundary outputs changed outside update");

    // RL18: instruction moves only in update or reset
    a_ir_only_update: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL18
        // Latch moves on the fall, under the state sampled at this rise
        !$stable(ir_cur) |-> (t_reg.state == ST_UPDIR || t_reg.state == ST_TLR))
        else $error("instruction changed outside update");

    // RL10: pause keeps boundary shift data
    a_pause_hold: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL10
        (t_reg.state == ST_PSDR) && !tms |=> (t_reg.state == ST_PSDR) ##0 $stable(t_reg.bsr_sh))
        else $error("pause did not hold");

    // RL13: Select-IR with high TMS resets
    a_sel_ir_reset: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL13
        (t_reg.state == ST_SELIR) && tms |=> (t_reg.state == ST_TLR))
        else $error("Select-IR high did not reset");

    // RL2: reset state restores the identify instruction
    a_tlr_idcode: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL2
        (t_reg.state == ST_TLR) ##1 (t_reg.state == ST_TLR) |-> (ir_cur == `TAP_OP_IDCODE))
        else $error("reset state lacks identify instruction");

    // RL11: Exit2-DR resume or update
    a_ex2dr_path: assert property (@(posedge tck) disable iff (!tck_rst_b) // RL11
        (t_reg.state == ST_EX2DR) |=>
            (t_reg.state == ($past(tms) ? ST_UPDDR : ST_SHDR)))
        else $error("wrong move from Exit2-DR");

endmodule

// ---- sim/tap_tester.sv ----
`timescale 1ns/100ps

// Boundary-scan tester: owns the test clock and the serial inputs
module tap_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Test clock rests low between steps
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; mode and data held across the rise
    task automatic step(input logic m, input logic d, output logic so, output logic soe);
        tms = m;
        tdi = d;
        #6;
        so = tdo;
        soe = tdo_oe;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask
endmodule

// ---- sim/jtag_tap_state_machine_tb.sv ----
`timescale 1ns/100ps
`include "tap_consts.svh"

// Self-checking bench: tester model plus reference state machine
module jtag_tap_state_machine_tb;
    // Cycle ceiling against hangs
    localparam int LIMIT = 20000;
    // Identification fields, values arbitrary
    localparam logic [3:0] VER = 4'h3;
    localparam logic [15:0] PART = 16'h5A6B;
    localparam logic [10:0] MFR = 11'h2C7;
    // Next state per state, one nibble each, for mode low and high
    localparam logic [63:0] N0 = 64'h1BDDBBA146644311;
    localparam logic [63:0] N1 = 64'h2FEFCC0287855920;

    logic mclk, rst_b, tck, tms, tdi, tdo, tdo_oe;
    logic [77:0] pins, pins_out, dr, bsr_exp; // Pins and model registers
    logic bsr_drive, test_drive, test_highz, test_reset;
    logic [2:0] ir, ir_sh; // Model instruction and its shift stage
    logic so_x, soe_x; // Unused samples during reset
    int st, err_total, cmp_count, cyc, seed, i, k;

    tap_controller #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pins_in(pins), .bsr_pins_out(pins_out),
        .bsr_drive(bsr_drive), .test_drive(test_drive), .test_highz(test_highz),
        .test_reset(test_reset)
    );

    tap_tester tester_u (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    // Compare one observed value with the model
    task automatic check(input logic [77:0] seen, input logic [77:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Length of the data register an instruction selects
    function automatic int dlen(input logic [2:0] op);
        return (op == 3'h0 || op == 3'h6) ? 78 : (op == 3'h1) ? 32 : 1;
    endfunction

    // One test clock with model update and port comparison
    task automatic tick(input logic m, input logic d);
        logic so, soe;
        int n;
        n = dlen(ir);
        // Latched outputs read mid low phase, well after the last fall
        fork
            tester_u.step(m, d, so, soe);
            #3 check(pins_out, bsr_exp);
        join
        check(soe, st == 4 || st == 11);
        if (st == 4) check(so, dr[0]);
        if (st == 11) check(so, ir_sh[0]);
        if (st == 3) dr = (n == 78) ? pins : (n == 32) ? {VER, PART, MFR, 1'b1} : 78'h0;
        if (st == 4) begin
            dr = dr >> 1;
            dr[n-1] = d;
        end
        if (st == 10) ir_sh = `TAP_IR_CAPTURE;
        if (st == 11) ir_sh = {d, ir_sh[2:1]};
        st = m ? int'(N1[st*4 +: 4]) : int'(N0[st*4 +: 4]);
        if (st == 8 && n == 78) bsr_exp = dr;
        if (st == 15) ir = ir_sh;
        if (st == 0) ir = `TAP_OP_IDCODE;
    endtask

    // Settle the system-side levels and compare with the model
    task automatic levels();
        repeat (4) @(negedge mclk);
        check(test_reset, st == 0);
        check(test_highz, st != 0 && ir == 3'h2);
        check(test_drive, st != 0 && (ir == 3'h0 || ir == 3'h3));
        check(bsr_drive, st != 0 && (ir == 3'h0 || ir == 3'h3));
    endtask

    // Full scan from idle; pause path taken on request
    task automatic scan(input logic irb, input logic [77:0] v, input int n, input logic pz);
        tick(1'b1, 1'b0);
        if (irb) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        for (int j = 0; j < n; j++) tick(j == n - 1, v[j]);
        if (pz) begin
            tick(1'b0, 1'b0);
            tick(1'b0, 1'b0);
            tick(1'b1, 1'b0);
        end
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // System clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        seed = 47;
        rst_b = 1'b0;
        pins = 78'h0;
        st = 0;
        ir = `TAP_OP_IDCODE;
        ir_sh = 3'h0;
        dr = 78'h0;
        bsr_exp = 78'h0;
        #3.3;
        // Test clock keeps running through the system reset
        fork
            begin
                repeat (6) @(negedge mclk);
                rst_b = 1'b1;
            end
            repeat (7) tester_u.step(1'b1, 1'b0, so_x, soe_x);
        join
        for (k = 0; k < 3; k++) tick(1'b1, 1'b0);
        levels();
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        // Every instruction code, each followed by a data scan
        for (i = 0; i < 8; i++) begin
            @(negedge mclk);
            pins = 78'({$random(seed), $random(seed), $random(seed)});
            scan(1'b1, 78'(i), 3, i[0]);
            scan(1'b0, 78'({$random(seed), $random(seed), $random(seed)}), dlen(ir), i[1]);
            tick(1'b0, 1'b0);
            levels();
        end
        @(negedge mclk);
        pins = 78'({$random(seed), $random(seed), $random(seed)});
        for (k = 0; k < 5; k++) tick(1'b1, 1'b0);
        for (k = 0; k < 600; k++) tick(($random(seed) & 3) == 0, 1'($random(seed)));
        // five high edges from wherever the walk stopped
        for (k = 0; k < 5; k++) tick(1'b1, 1'b0);
        tick(1'b1, 1'b0);
        levels();
        // identification selected after the forced reset
        tick(1'b0, 1'b0);
        scan(1'b0, 78'h0, 32, 1'b0);
        tally_and_finish();
    end
endmodule
